// File: rtl/tks_keying_seq.sv
// Transmit keying sequencer: relay and bias stepping, lockout, lockon, key-out gating, motor commands.
// Assumes key, talk, RF sense and bias clamp are asynchronous pins; registers over classic Wishbone.
`timescale 1ns/1ns
`include "tks_regs.svh"
// Operation
// - Key or talk input starts the step progression.
// - Key released and no lockon: step held at zero, relays, bias and key-out off.
// - Output relay at step 1, input relay step 2, bias step 10, in order.
// - Step rate and step chosen per output are software adjustable.
// - Ready indication from final step; high while off or sequencing.
// - RF before completion forces step zero while RF persists.
// - Online with RF present holds completed state despite key release.
// - Outside standby, key-out only while key closed and online; postponed until done.
// - Bias clamp input suppresses bias enable regardless of sequence.
// - Three identical motor channels: tune, load, bandswitch.
// - Low speed chops motor on with a low-duty square wave.
// - Bandswitch motor blocked while bias enable is active.
// - Standby blocks keying, passes key through; operate key+talk; break-in key only.
module tks_keying_seq #(
  parameter logic [15:0] STEP_CYCLES = 16'(`TKS_STEP_CYCLES),
  parameter int          LOW_PERIOD  = `TKS_LOW_PERIOD_CYC,
  parameter int          LOW_DUTY    = `TKS_LOW_ON_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        key_in,
  input  wire logic        ptt_in,
  input  wire logic        rf_sense_in,
  input  wire logic        bias_clamp_in,
  output logic             out_relay_o,
  output logic             in_relay_o,
  output logic             bias_en_o,
  output logic             key_out_o,
  output logic             sequence_done_step_n,
  output logic      [2:0]  motor_on_o,
  output logic      [2:0]  motor_dir_o
);
  localparam int NMOT = 3;

  tks_pkg::tks_state_s s_q;
  tks_pkg::tks_state_s s_d;

  logic [3:0]        pins_s;
  logic              key_s;
  logic              ptt_s;
  logic              rf_s;
  logic              clamp_s;
  logic              standby;
  logic              key_req;
  logic              done;
  logic              lockout;
  logic              lockon;
  logic              wb_hit;
  logic [2:0]        reg_idx;
  logic [31:0]       status;
  logic [31:0]       wr_word;
  tks_pkg::tks_step_t sel_out;
  tks_pkg::tks_step_t sel_in;
  tks_pkg::tks_step_t sel_bias;

  tks_motor_if #(.N(NMOT)) mif ();

  tks_sync #(
    .W (4)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({bias_clamp_in, rf_sense_in, ptt_in, key_in}),
    .sync_out (pins_s)
  );

  assign key_s   = pins_s[0];
  assign ptt_s   = pins_s[1];
  assign rf_s    = pins_s[2];
  assign clamp_s = pins_s[3];

  // Register index decode; 3'h7 marks an unmapped word
  function automatic logic [2:0] tks_reg_index(input logic [7:0] adr);
    logic [2:0] idx;
    idx = 3'h7;
    if (adr == `TKS_ADDR_CTRL)
      idx = 3'h0;
    else if (adr == `TKS_ADDR_RATE)
      idx = 3'h1;
    else if (adr == `TKS_ADDR_SEL)
      idx = 3'h2;
    else if (adr == `TKS_ADDR_MOTOR)
      idx = 3'h3;
    else if (adr == `TKS_ADDR_STATUS)
      idx = 3'h4;
    return idx;
  endfunction

  function automatic logic [31:0] tks_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction

  // Mode gating: standby keys nothing, path enables pick key and talk
  assign standby  = s_q.ctrl[`TKS_CTRL_STANDBY];
  assign key_req  = !standby && ((key_s && s_q.ctrl[`TKS_CTRL_KEY]) ||
                                 (ptt_s && s_q.ctrl[`TKS_CTRL_TALK]));
  assign done     = (s_q.step == `TKS_STEP_LAST);
  assign lockout  = !done && rf_s;
  assign lockon   = done && rf_s;
  assign sel_out  = s_q.sel[`TKS_SEL_OUT_LSB +: 4];
  assign sel_in   = s_q.sel[`TKS_SEL_IN_LSB +: 4];
  assign sel_bias = s_q.sel[`TKS_SEL_BIAS_LSB +: 4];
  assign wb_hit   = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign reg_idx  = tks_reg_index(wb_adr_i);

  always_comb
  begin
    status                                = '0;
    status[`TKS_ST_STEP_LSB +: 4]         = s_q.step;
    status[`TKS_ST_DONE]                  = !s_q.done_n;
    status[`TKS_ST_OUT_RELAY]             = s_q.out_relay;
    status[`TKS_ST_IN_RELAY]              = s_q.in_relay;
    status[`TKS_ST_BIAS]                  = s_q.bias_en;
    status[`TKS_ST_KEY_OUT]               = s_q.key_out;
    status[`TKS_ST_RF]                    = rf_s;
    status[`TKS_ST_LOCKOUT]               = lockout;
    status[`TKS_ST_LOCKON]                = lockon;
    status[`TKS_ST_CLAMP]                 = clamp_s;
  end

  always_comb
  begin
    s_d     = s_q;
    wr_word = 32'h0000_0000;
    // Ack for one cycle per request; the master must drop stb before the next
    s_d.ack = wb_hit;
    if (wb_hit && wb_we_i)
    begin
      // Only enabled bytes change; bits above a field are dropped on purpose
      unique case (reg_idx)
        3'h0:
        begin
          wr_word  = tks_merge(32'(s_q.ctrl), wb_dat_i, wb_sel_i);
          s_d.ctrl = wr_word[2:0];
        end
        3'h1:
        begin
          wr_word  = tks_merge(32'(s_q.rate), wb_dat_i, wb_sel_i);
          s_d.rate = wr_word[15:0];
        end
        3'h2:
        begin
          wr_word = tks_merge(32'(s_q.sel), wb_dat_i, wb_sel_i);
          s_d.sel = wr_word[11:0];
        end
        3'h3:
        begin
          wr_word   = tks_merge(32'(s_q.motor), wb_dat_i, wb_sel_i);
          s_d.motor = wr_word[8:0];
        end
        default: s_d.motor = s_q.motor;
      endcase
    end
    if (wb_hit && !wb_we_i)
    begin
      unique case (reg_idx)
        3'h0: s_d.dat = 32'(s_q.ctrl);
        3'h1: s_d.dat = 32'(s_q.rate);
        3'h2: s_d.dat = 32'(s_q.sel);
        3'h3: s_d.dat = 32'(s_q.motor);
        3'h4: s_d.dat = status;
        default: s_d.dat = 32'h0000_0000;
      endcase
    end

    // Step progression; RF sensed mid-sequence wins over everything
    if (lockout)
    begin
      s_d.step  = '0;
      s_d.presc = '0;
    end
    else if (lockon)
    begin
      s_d.step  = s_q.step;
      s_d.presc = '0;
    end
    else if (!key_req)
    begin
      s_d.step  = '0;
      s_d.presc = '0;
    end
    else if (!done)
    begin
      // A rate of zero behaves as one so the ramp never stalls
      if (s_q.presc + 16'h0001 >= s_q.rate)
      begin
        s_d.presc = '0;
        s_d.step  = s_q.step + 4'h1;
      end
      else
        s_d.presc = s_q.presc + 16'h0001;
    end

    // Outputs from the next step, so they move on the same edge as the step
    s_d.out_relay = (s_d.step != '0) && (s_d.step >= sel_out);
    s_d.in_relay  = (s_d.step != '0) && (s_d.step >= sel_in);
    s_d.bias_en   = (s_d.step != '0) && (s_d.step >= sel_bias) && !clamp_s;
    s_d.done_n    = (s_d.step != `TKS_STEP_LAST);
    // Gating key-out on the final step keeps the exciter from racing the relays
    s_d.key_out   = standby ? key_s : (key_s && (s_d.step == `TKS_STEP_LAST));
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q        <= '0;
      s_q.ctrl   <= `TKS_CTRL_RESET;
      s_q.rate   <= STEP_CYCLES;
      s_q.sel    <= `TKS_SEL_RESET;
      s_q.motor  <= `TKS_MOT_RESET;
      s_q.done_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Motor command lines, three per channel
  for (genvar i = 0; i < NMOT; i++)
  begin : g_mot
    assign mif.on[i]   = s_q.motor[i*`TKS_MOT_STRIDE + `TKS_MOT_ON];
    assign mif.fast[i] = s_q.motor[i*`TKS_MOT_STRIDE + `TKS_MOT_FAST];
    assign mif.dir[i]  = s_q.motor[i*`TKS_MOT_STRIDE + `TKS_MOT_DIR];
  end
  assign mif.bias_active = s_d.bias_en | s_q.bias_en;

  tks_motor_drv #(
    .N      (NMOT),
    .PERIOD (LOW_PERIOD),
    .DUTY   (LOW_DUTY)
  ) u_motor (
    .core_clk (core_clk),
    .rst      (rst),
    .mif      (mif)
  );

  assign wb_dat_o             = s_q.dat;
  assign wb_ack_o             = s_q.ack;
  assign out_relay_o          = s_q.out_relay;
  assign in_relay_o           = s_q.in_relay;
  assign bias_en_o            = s_q.bias_en;
  assign key_out_o            = s_q.key_out;
  assign sequence_done_step_n = s_q.done_n;
  assign motor_on_o           = mif.drive_on;
  assign motor_dir_o          = mif.drive_dir;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  step_start_a: assert property (
    (s_q.step != $past(s_q.step) && s_q.step != '0) |-> $past(key_req))
    else $error("step advanced without a keying request");
  idle_zero_a: assert property (
    (!key_req && !lockon) |=> (s_q.step == '0 && !out_relay_o && !in_relay_o && !bias_en_o))
    else $error("outputs not off while unkeyed");
  relay_order_a: assert property (
    (sel_out <= sel_in && sel_in <= sel_bias && bias_en_o) |-> (in_relay_o && out_relay_o))
    else $error("bias enabled before relays");
  done_flag_a: assert property (
    $fell(sequence_done_step_n) |-> (s_q.step == `TKS_STEP_LAST && $past(s_q.step) == 4'h9))
    else $error("ready shown without completing the sequence");
  lockout_hold_a: assert property (
    (rf_s && !done) |=> (s_q.step == '0 && sequence_done_step_n))
    else $error("lockout failed to force step zero");
  lockon_hold_a: assert property (
    (done && rf_s) |=> (done && !sequence_done_step_n))
    else $error("lockon released under RF");
  key_gate_a: assert property (
    (key_out_o && !$past(standby)) |-> (!sequence_done_step_n && $past(key_s)))
    else $error("key out asserted while offline");
  clamp_bias_a: assert property (
    clamp_s |=> !bias_en_o)
    else $error("bias enabled under clamp");
  standby_pass_a: assert property (
    standby |=> (key_out_o == $past(key_s) && s_q.step == '0))
    else $error("standby did not pass key through");
  wb_ack_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  seq_done_c: cover property ($fell(sequence_done_step_n));
  lockout_c: cover property (rf_s && !done && s_q.step != '0);
  lockon_c: cover property (lockon && !key_req);
  key_out_c: cover property ($rose(key_out_o) && !standby);
endmodule // tks_keying_seq

// File: rtl/tks_regs.svh
// Register offsets, field positions, reset values and timing counts of the keying sequencer.
// Assumes a 100 MHz core clock and 32-bit classic Wishbone register access.
`ifndef TKS_REGS_SVH
`define TKS_REGS_SVH

`define TKS_ADDR_CTRL       8'h00
`define TKS_ADDR_RATE       8'h04
`define TKS_ADDR_SEL        8'h08
`define TKS_ADDR_MOTOR      8'h0C
`define TKS_ADDR_STATUS     8'h10

`define TKS_CTRL_STANDBY    0
`define TKS_CTRL_KEY        1
`define TKS_CTRL_TALK       2
`define TKS_CTRL_RESET      3'h1

`define TKS_SEL_OUT_LSB     0
`define TKS_SEL_IN_LSB      4
`define TKS_SEL_BIAS_LSB    8
`define TKS_SEL_RESET       12'hA21

`define TKS_MOT_ON          0
`define TKS_MOT_FAST        1
`define TKS_MOT_DIR         2
`define TKS_MOT_STRIDE      3
`define TKS_MOT_RESET       9'h000

`define TKS_ST_STEP_LSB     0
`define TKS_ST_DONE         4
`define TKS_ST_OUT_RELAY    5
`define TKS_ST_IN_RELAY     6
`define TKS_ST_BIAS         7
`define TKS_ST_KEY_OUT      8
`define TKS_ST_RF           9
`define TKS_ST_LOCKOUT      10
`define TKS_ST_LOCKON       11
`define TKS_ST_CLAMP        12

`define TKS_STEP_LAST       4'hA
`define TKS_CLK_PERIOD_NS   10
`define TKS_STEP_TIME_NS    300000
`define TKS_STEP_CYCLES     (`TKS_STEP_TIME_NS / `TKS_CLK_PERIOD_NS)
`define TKS_LOW_PERIOD_NS   10000
`define TKS_LOW_ON_NS       2000
`define TKS_LOW_PERIOD_CYC  (`TKS_LOW_PERIOD_NS / `TKS_CLK_PERIOD_NS)
`define TKS_LOW_ON_CYC      (`TKS_LOW_ON_NS / `TKS_CLK_PERIOD_NS)

`endif

// File: rtl/tks_pkg.sv
// Types shared by the keying sequencer modules.
// Assumes tks_regs.svh supplies all numeric constants.
package tks_pkg;

  typedef logic [3:0] tks_step_t;

  typedef struct packed {
    logic [2:0]  ctrl;
    logic [15:0] rate;
    logic [11:0] sel;
    logic [8:0]  motor;
    logic [15:0] presc;
    tks_step_t   step;
    logic        out_relay;
    logic        in_relay;
    logic        bias_en;
    logic        key_out;
    logic        done_n;
    logic        ack;
    logic [31:0] dat;
  } tks_state_s;

endpackage

// File: rtl/tks_motor_if.sv
// Motor command and drive bundle between the sequencer core and the motor driver.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ns
interface tks_motor_if #(parameter int N = 3);
  logic [N-1:0] on;
  logic [N-1:0] fast;
  logic [N-1:0] dir;
  logic         bias_active;
  logic [N-1:0] drive_on;
  logic [N-1:0] drive_dir;
  modport ctl (output on, output fast, output dir, output bias_active, input drive_on, input drive_dir);
  modport drv (input on, input fast, input dir, input bias_active, output drive_on, output drive_dir);
endinterface

// File: rtl/tks_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/1ns
module tks_sync #(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } tks_sync_state_s;

  tks_sync_state_s s_q;
  tks_sync_state_s s_d;

  // First stage feeds only the second; a change counts once stages two and three agree
  always_comb
  begin
    s_d     = s_q;
    s_d.s1  = async_in;
    s_d.s2  = s_q.s1;
    s_d.s3  = s_q.s2;
    s_d.out = (s_q.s2 & s_q.s3) | (s_q.out & (s_q.s2 ^ s_q.s3));
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sync_out = s_q.out;
endmodule // tks_sync

// File: rtl/tks_motor_drv.sv
// Motor channel drivers with low-speed chopping and bandswitch bias interlock.
// Assumes channel N-1 is the bandswitch and commands come from registers on core_clk.
`timescale 1ns/1ns
`include "tks_regs.svh"
module tks_motor_drv #(
  parameter int N      = 3,
  parameter int PERIOD = `TKS_LOW_PERIOD_CYC,
  parameter int DUTY   = `TKS_LOW_ON_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst,
  tks_motor_if.drv  mif
);
  localparam int CW = $clog2(PERIOD);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [N-1:0]  on;
    logic [N-1:0]  dir;
  } tks_motor_state_s;

  tks_motor_state_s s_q;
  tks_motor_state_s s_d;
  logic             wave;

  always_comb
  begin
    s_d   = s_q;
    // Free-running chopper, so slow motion has a fixed low duty
    s_d.cnt = (s_q.cnt == CW'(PERIOD - 1)) ? '0 : s_q.cnt + 1'b1;
    wave    = (s_q.cnt < CW'(DUTY));
    for (int i = 0; i < N; i++)
    begin
      // Each channel is the same: on, speed and direction lines
      s_d.on[i]  = mif.on[i] & (mif.fast[i] | wave);
      s_d.dir[i] = mif.dir[i];
    end
    // Bandswitch must not move while tubes are biased on
    s_d.on[N-1] = s_d.on[N-1] & ~mif.bias_active;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign mif.drive_on  = s_q.on;
  assign mif.drive_dir = s_q.dir;

  band_lock_a: assert property (@(posedge core_clk) disable iff (rst)
    mif.bias_active |=> !mif.drive_on[N-1])
    else $error("bandswitch driven while bias active");
  slow_chop_a: assert property (@(posedge core_clk) disable iff (rst)
    (!mif.fast[0] && !wave) |=> !mif.drive_on[0])
    else $error("low speed channel driven outside chopper window");
  fast_drive_a: assert property (@(posedge core_clk) disable iff (rst)
    (mif.on[1] && mif.fast[1]) |=> mif.drive_on[1])
    else $error("fast channel not driven");
  slow_run_c: cover property (@(posedge core_clk) disable iff (rst)
    mif.on[0] && !mif.fast[0] ##1 mif.drive_on[0]);
endmodule // tks_motor_drv

// File: testbench/tks_exciter_model.sv
// Stand-in for the exciter and the supervising controller at the keying pins.
// Assumes the sequencer's core clock; every pin changes just after a rising edge.
`timescale 1ns/1ns
module tks_exciter_model (
  input  wire logic core_clk,
  input  wire logic key_cmd,
  input  wire logic ptt_cmd,
  input  wire logic clamp_cmd,
  input  wire logic hot_rf,
  input  wire logic key_out_o,
  output logic      key_in = 1'b0,
  output logic      ptt_in = 1'b0,
  output logic      rf_sense_in = 1'b0,
  output logic      bias_clamp_in = 1'b0
);
  // Exciter radiates one clock after it is keyed out; hot_rf models a drive tail or an early exciter
  always @(posedge core_clk)
  begin
    key_in        <= key_cmd;
    ptt_in        <= ptt_cmd;
    bias_clamp_in <= clamp_cmd;
    rf_sense_in   <= hot_rf | key_out_o;
  end
endmodule // tks_exciter_model

// File: testbench/test_tks_keying_seq.sv
// Self-checking bench of the keying sequencer: register calls, keying scenarios, motor drive.
// Assumes short sim counts: two clocks a step, chopper period 8 with 2 clocks on.
`timescale 1ns/1ns
`include "tks_regs.svh"
module test_tks_keying_seq;
  localparam int LP = 8;
  localparam int LD = 2;
  logic        core_clk, rst, cyc, stb, we, ack, key, ptt, clamp, hot;
  logic        key_in, ptt_in, rf_in, clamp_in, outr, inr, bias, kout, done_n;
  logic [7:0]  adr;
  logic [31:0] dat, dat_o, rd;
  logic [2:0]  mon, mdir;
  int          mismatches, samples_checked, n, c;

  tks_keying_seq #(.STEP_CYCLES(16'h0002), .LOW_PERIOD(LP), .LOW_DUTY(LD)) i_tks_keying_seq (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .key_in(key_in), .ptt_in(ptt_in),
    .rf_sense_in(rf_in), .bias_clamp_in(clamp_in), .out_relay_o(outr), .in_relay_o(inr), .bias_en_o(bias),
    .key_out_o(kout), .sequence_done_step_n(done_n), .motor_on_o(mon), .motor_dir_o(mdir));

  tks_exciter_model i_tks_exciter_model (
    .core_clk(core_clk), .key_cmd(key), .ptt_cmd(ptt), .clamp_cmd(clamp), .hot_rf(hot), .key_out_o(kout),
    .key_in(key_in), .ptt_in(ptt_in), .rf_sense_in(rf_in), .bias_clamp_in(clamp_in));

  task automatic fail(input string m);
    mismatches++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) fail($sformatf("%s got %h expected %h", m, g, e));
  endtask

  // Held request until ack is sampled; the next call waits an edge, so stb idles a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge core_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    if (k >= 50) fail("no bus answer");
  endtask

  // Counts edges until s shows v, bounded
  task automatic waitv(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v && k < 300)
    begin
      @(posedge core_clk);
      k++;
    end
    if (s !== v) fail("level never reached");
  endtask

  task automatic wrap_up();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail("watchdog expired");
    wrap_up();
  end

  initial
  begin
    {rst, cyc, stb, we, key, ptt, clamp, hot} = 8'h80;
    adr = 8'h00; dat = 32'h0;
    mismatches = 0; samples_checked = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    wb(0, `TKS_ADDR_CTRL, 0, rd); chk(rd, 32'h1, "ctrl reset");
    wb(0, `TKS_ADDR_SEL, 0, rd); chk(rd, 32'hA21, "sel reset");
    wb(0, `TKS_ADDR_RATE, 0, rd); chk(rd, 32'h2, "rate reset");
    wb(0, 8'h14, 32'hFF, rd); chk(rd, 32'h0, "unmapped read");
    // Standby: key passes straight out, relays stay open
    key <= 1'b1;
    waitv(kout, 1'b1, n); chk({outr, inr, bias}, 0, "standby keyed");
    key <= 1'b0;
    waitv(kout, 1'b0, n);
    // Operate: key held early, bring-up in order, key-out postponed
    wb(1, `TKS_ADDR_CTRL, 32'h6, rd);
    key <= 1'b1;
    waitv(outr, 1'b1, n); chk({inr, bias, kout, done_n}, 4'b0001, "step1");
    waitv(inr, 1'b1, n); chk({bias, done_n}, 2'b01, "step2");
    waitv(bias, 1'b1, n); chk({done_n, kout}, 2'b01, "online");
    wb(1, `TKS_ADDR_MOTOR, 32'h0C0, rd);
    repeat (4) @(posedge core_clk);
    chk(mon, 3'b000, "bandswitch under bias");
    clamp <= 1'b1;
    waitv(bias, 1'b0, n); chk(done_n, 1'b0, "clamped online");
    clamp <= 1'b0;
    waitv(bias, 1'b1, n);
    // Lockon: key released under RF keeps relays closed
    hot <= 1'b1; key <= 1'b0;
    repeat (30) @(posedge core_clk);
    chk({outr, done_n, kout}, 3'b100, "lockon");
    wb(0, `TKS_ADDR_STATUS, 0, rd); chk(rd, 32'h0000_0AFA, "status lockon");
    hot <= 1'b0;
    waitv(outr, 1'b0, n); chk({inr, bias, done_n}, 3'b001, "released");
    repeat (4) @(posedge core_clk);
    chk(mon, 3'b100, "bandswitch free");
    // Lockout: RF mid-ramp drops back to step zero and keeps the amplifier offline
    key <= 1'b1;
    waitv(outr, 1'b1, n);
    hot <= 1'b1;
    waitv(outr, 1'b0, n); chk(done_n, 1'b1, "lockout mid-ramp");
    repeat (40) @(posedge core_clk);
    chk({outr, done_n}, 2'b01, "lockout");
    hot <= 1'b0;
    waitv(done_n, 1'b0, n);
    key <= 1'b0;
    waitv(outr, 1'b0, n);
    // Break-in: talk ignored, key honoured
    wb(1, `TKS_ADDR_CTRL, 32'h2, rd);
    ptt <= 1'b1;
    repeat (40) @(posedge core_clk);
    chk(outr, 1'b0, "talk in break-in");
    key <= 1'b1;
    waitv(outr, 1'b1, n);
    key <= 1'b0;
    waitv(outr, 1'b0, n);
    // Operate by talk alone: online, but no key-out without key
    wb(1, `TKS_ADDR_CTRL, 32'h6, rd);
    waitv(bias, 1'b1, n); chk(kout, 1'b0, "talk key-out");
    ptt <= 1'b0;
    waitv(outr, 1'b0, n);
    // Adjustable rate and steps: out at step 1, bias at step 5, three clocks a step
    wb(1, `TKS_ADDR_RATE, 32'h3, rd);
    wb(1, `TKS_ADDR_SEL, 32'h531, rd);
    key <= 1'b1;
    waitv(outr, 1'b1, n);
    waitv(bias, 1'b1, n); chk(n, 4 * 3, "step spacing");
    key <= 1'b0;
    waitv(outr, 1'b0, n);
    // Each motor channel alike: on, fast, direction
    for (c = 0; c < 3; c++)
    begin
      wb(1, `TKS_ADDR_MOTOR, 32'h7 << (3 * c), rd);
      repeat (3) @(posedge core_clk);
      chk({mdir, mon}, {2{3'b001 << c}}, "motor channel");
    end
    // Slow speed: on for LD clocks of every LP
    wb(1, `TKS_ADDR_MOTOR, 32'h1, rd);
    repeat (3) @(posedge core_clk);
    n = 0;
    repeat (2 * LP)
    begin
      @(posedge core_clk);
      n += int'(mon[0] === 1'b1);
    end
    chk(n, 2 * LD, "slow duty");
    wrap_up();
  end
endmodule // test_tks_keying_seq
